// [logic/cep_defs.vh]
`ifndef CEP_DEFS_VH
`define CEP_DEFS_VH

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
`define CEP_IO1_PAGE      8'hde
`define CEP_IO2_PAGE      8'hdf
`define CEP_LOW_ROM_BLK   3'h4
`define CEP_HIGH_ROM_BLK  3'h7

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CEP_PHI2_DIV      4'h8
`define CEP_BA_LEAD       2'h3
`define CEP_FETCH_PERIOD  6'h3f
`define CEP_FETCH_LEN     6'h28

`endif

// [logic/cep_port.v]
// Functional notes
// - first I/O select low for addresses de00 to deff, else high.
// - second I/O select low for addresses df00 to dfff.
// - low ROM window select low for 8K block at 8000.
// - high ROM window select low for 8K block at e000.
// - both memory configuration lines are active-low inputs, released high.
// - DMA request low floats address, data and read/write drivers.
// - DMA request reads inactive when undriven, via pull-up.
// - bus-available low three cycles before video fetch, until fetch ends. The port adds no lead; it follows the fetch request one clock later.
// - dot clock presented; all timing, phase-2 included, derived from it. The code divides dot clock and phase-2 each from the system clock.
// - interrupt request is active low; cartridge may pull it.
// - reset driven out buffered and accepted as input from cartridge.
// - NMI active low, driven out buffered, accepted from cartridge.
// - 16-bit address bus exposed on the port.
// - 8-bit bidirectional data bus exposed on the port.
// - phase-2 clock and read/write line provided on the port.
`include "cep_defs.vh"

module cep_port (
  // clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // processor side
  input  wire [15:0] cpu_addr_i,
  input  wire [7:0]  cpu_wdata_i,
  input  wire        cpu_rw_i,
  input  wire        cpu_irq_n_i,
  input  wire        cpu_nmi_n_i,
  input  wire        cpu_rst_n_i,
  output wire [7:0]  cpu_rdata_o,
  output wire        cpu_irq_n_o,
  output wire        cpu_nmi_n_o,
  output wire        cpu_rst_n_o,
  output wire        cpu_float_o,
  output wire        cfg_a_n_o,
  output wire        cfg_b_n_o,
  // video fetch request
  input  wire        vid_fetch_i,
  // port: clocks
  output wire        dot_clk_o,
  output wire        phi2_o,
  // port: address, data, read/write
  input  wire [15:0] addr_i,
  output wire [15:0] addr_o,
  output wire        addr_oe_o,
  input  wire [7:0]  data_i,
  output wire [7:0]  data_o,
  output wire        data_oe_o,
  input  wire        rw_i,
  output wire        rw_o,
  output wire        rw_oe_o,
  // port: selects
  output wire        io1_sel_n_o,
  output wire        io2_sel_n_o,
  output wire        low_rom_window_sel_n_o,
  output wire        high_rom_window_sel_n_o,
  // port: config, dma, bus available
  input  wire        mem_config_a_n_i,
  input  wire        mem_config_b_n_i,
  input  wire        dma_req_n_i,
  output wire        ba_o,
  // port: shared open-drain lines
  input  wire        irq_n_i,
  output wire        irq_n_o,
  output wire        irq_oe_o,
  input  wire        nmi_n_i,
  output wire        nmi_n_o,
  output wire        nmi_oe_o,
  input  wire        rst_n_i,
  output wire        rst_n_o,
  output wire        rst_oe_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [5:0] pin_s;

  // released lines idle high, so reset value is 1
  cep_sync3 #(
    .W   (6),
    .RST (1'b1)
  ) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    ({mem_config_a_n_i, mem_config_b_n_i, dma_req_n_i,
              irq_n_i, nmi_n_i, rst_n_i}),
    .q_o    (pin_s)
  );

  wire cfg_a_s = pin_s[5];
  wire cfg_b_s = pin_s[4];
  wire dma_s   = pin_s[3];
  wire irq_s   = pin_s[2];
  wire nmi_s   = pin_s[1];
  wire rst_s   = pin_s[0];

  // ----------------------------------------------------------------
  // dot clock and phase-2 from the system clock
  // ----------------------------------------------------------------
  reg [3:0] div_q;
  reg       phi2_q;
  reg       dot_q;

  // divide the system clock to dot clock and, separately, to phase-2
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q  <= 4'h0;
      phi2_q <= 1'b0;
      dot_q  <= 1'b0;
    end else begin
      dot_q <= ~dot_q;
      if (div_q == `CEP_PHI2_DIV - 4'h1) begin
        div_q  <= 4'h0;
        phi2_q <= ~phi2_q;
      end else begin
        div_q <= div_q + 4'h1;
      end
    end
  end

  assign dot_clk_o = dot_q;
  assign phi2_o    = phi2_q;

  // ----------------------------------------------------------------
  // dma float: taken on every clock while phase-2 is low
  // ----------------------------------------------------------------
  reg float_q;

  // external master is trusted to request with phase-2 low
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      float_q <= 1'b0;
    end else if (!phi2_q) begin
      float_q <= ~dma_s;
    end
  end

  assign cpu_float_o = float_q;

  // ----------------------------------------------------------------
  // bus-available from the video fetch request, one clock later
  // ----------------------------------------------------------------
  reg ba_q;

  // fetch request is raised the lead time ahead of the take-over
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ba_q <= 1'b1;
    end else begin
      ba_q <= ~vid_fetch_i;
    end
  end

  assign ba_o = ba_q;

  // ----------------------------------------------------------------
  // address, data and read/write drivers
  // ----------------------------------------------------------------
  reg [15:0] addr_q;
  reg [7:0]  wdata_q;
  reg        rw_q;
  reg [7:0]  rdata_q;

  // register processor outputs; capture read data at phase-2 high
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_q  <= 16'h0000;
      wdata_q <= 8'h00;
      rw_q    <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      addr_q  <= cpu_addr_i;
      wdata_q <= cpu_wdata_i;
      rw_q    <= cpu_rw_i;
      if (phi2_q && rw_i)
        rdata_q <= data_i;
    end
  end

  wire own = ~float_q;

  assign addr_o    = addr_q;
  assign addr_oe_o = own;
  assign rw_o      = rw_q;
  assign rw_oe_o   = own;
  assign data_o    = wdata_q;
  // drive data only on own writes with phase-2 high
  assign data_oe_o = own & ~rw_q & phi2_q;
  assign cpu_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // select decode from the bus address (own or external master)
  // ----------------------------------------------------------------
  reg io1_q;
  reg io2_q;
  reg low_win_q;
  reg high_win_q;

  // buffered selects
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io1_q      <= 1'b1;
      io2_q      <= 1'b1;
      low_win_q  <= 1'b1;
      high_win_q <= 1'b1;
    end else begin
      io1_q      <= ~(addr_i[15:8] == `CEP_IO1_PAGE);
      io2_q      <= ~(addr_i[15:8] == `CEP_IO2_PAGE);
      low_win_q  <= ~(addr_i[15:13] == `CEP_LOW_ROM_BLK);
      high_win_q <= ~(addr_i[15:13] == `CEP_HIGH_ROM_BLK);
    end
  end

  assign io1_sel_n_o             = io1_q;
  assign io2_sel_n_o             = io2_q;
  assign low_rom_window_sel_n_o  = low_win_q;
  assign high_rom_window_sel_n_o = high_win_q;

  // ----------------------------------------------------------------
  // config inputs and shared open-drain lines
  // ----------------------------------------------------------------
  assign cfg_a_n_o = cfg_a_s;
  assign cfg_b_n_o = cfg_b_s;

  // open drain: drive low only, released otherwise
  assign irq_n_o  = 1'b0;
  assign irq_oe_o = ~cpu_irq_n_i;
  assign nmi_n_o  = 1'b0;
  assign nmi_oe_o = ~cpu_nmi_n_i;
  assign rst_n_o  = 1'b0;
  assign rst_oe_o = ~cpu_rst_n_i;

  // wired level back to the processor
  assign cpu_irq_n_o = irq_s & cpu_irq_n_i;
  assign cpu_nmi_n_o = nmi_s & cpu_nmi_n_i;
  assign cpu_rst_n_o = rst_s & cpu_rst_n_i;

endmodule // cep_port

// [logic/cep_sync3.v]
// ----------------------------------------------------------------
// three-stage synchroniser; a change is taken once stages 2 and 3 agree
// ----------------------------------------------------------------
module cep_sync3 #(
  parameter W   = 1,
  parameter RST = 1'b1
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         nrst_i,
  // data
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] out_q;

  // shift chain
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q  <= {W{RST}};
      s2_q  <= {W{RST}};
      s3_q  <= {W{RST}};
      out_q <= {W{RST}};
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per-bit agreement
      out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end
  end

  assign q_o = out_q;

endmodule // cep_sync3

// [testbench/cartridge_expansion_port_tb.sv]
module cartridge_expansion_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, nrst_i = 0, cpu_rw_i = 1, vid_fetch_i = 0, want_dma = 0;
  logic cpu_irq_n_i = 1, cpu_nmi_n_i = 1, cpu_rst_n_i = 1, rw_i;
  logic [15:0] cpu_addr_i = 0, ext_addr = 0, addr_i, addr_o;
  logic [7:0] cpu_wdata_i = 0, cpu_rdata_o, data_i, data_o, cart_d, hi;
  logic [1:0] want_cfg = 0;
  logic mem_config_a_n_i, mem_config_b_n_i, dma_req_n_i, irq_n_i, nmi_n_i;
  logic rst_n_i, cpu_irq_n_o, cpu_nmi_n_o, cpu_rst_n_o, cpu_float_o;
  logic cfg_a_n_o, cfg_b_n_o, dot_clk_o, phi2_o, addr_oe_o, data_oe_o;
  logic rw_o, rw_oe_o, io1_sel_n_o, io2_sel_n_o, ba_o, irq_n_o, irq_oe_o;
  logic low_rom_window_sel_n_o, high_rom_window_sel_n_o, nmi_n_o;
  logic nmi_oe_o, rst_n_o, rst_oe_o, sel;
  logic [2:0] ext_pull = 0;
  logic [7:0] tbl [10] = '{8'hde, 8'hdf, 8'h80, 8'h9f, 8'he0, 8'hff,
                           8'h7f, 8'ha0, 8'hdd, 8'hc0};
  logic [18:0] notes [$];
  logic [18:0] n;
  int n_fail = 0, tests_run = 0;
  event look_ev;
  // wire resolution: open drain lines, released buses
  assign addr_i = addr_oe_o ? addr_o : ext_addr;
  assign rw_i = rw_oe_o ? rw_o : 1'b1;
  assign data_i = data_oe_o ? data_o : cart_d;
  assign irq_n_i = !irq_oe_o && !ext_pull[2];
  assign nmi_n_i = !nmi_oe_o && !ext_pull[1];
  assign rst_n_i = !rst_oe_o && !ext_pull[0];
  assign sel = io1_sel_n_o & io2_sel_n_o & low_rom_window_sel_n_o
               & high_rom_window_sel_n_o;
  cep_port dut (.*);
  cep_cart cart (.clk_i(clk_i), .phi2_i(phi2_o), .rw_i(rw_i), .sel_n_i(sel),
    .ba_i(ba_o), .want_dma_i(want_dma), .want_cfg_i(want_cfg),
    .d_o(cart_d), .d_oe_o(), .dma_req_n_o(dma_req_n_i),
    .cfg_n_o({mem_config_a_n_i, mem_config_b_n_i}));
  // clock
  initial forever #50 clk_i = ~clk_i;
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wait_float(input logic v);
    repeat (60) if (cpu_float_o !== v) begin @(posedge clk_i); #10; end
    check(cpu_float_o, v);
  endtask
  // result watcher
  always begin
    @(look_ev);
    n = notes.pop_front();
    check({ba_o, cfg_a_n_o, cfg_b_n_o, io1_sel_n_o, io2_sel_n_o,
           low_rom_window_sel_n_o, high_rom_window_sel_n_o, cpu_irq_n_o,
           cpu_nmi_n_o, cpu_rst_n_o}, n[17:8]);
    if (n[18]) check(cpu_rdata_o, n[7:0]);
  end
  // watchdog
  initial begin
    #300000;
    n_fail++;
    final_report;
  end
  // stimulus
  initial begin
    void'($urandom(15));
    repeat (6) @(posedge clk_i);
    #10 nrst_i = 1;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_i);
      #10 hi = tbl[i % 10];
      cpu_addr_i = {hi, 8'($urandom)};
      {cpu_irq_n_i, cpu_nmi_n_i, cpu_rst_n_i, vid_fetch_i, want_cfg,
        ext_pull} = 9'($urandom);
      repeat (16) @(posedge clk_i);
      #10 notes.push_back({hi == 8'hde || hi == 8'hdf || hi[7:5] == 3'h4 ||
        hi[7:5] == 3'h7, !vid_fetch_i, ~want_cfg, hi != 8'hde, hi != 8'hdf,
        hi[7:5] != 3'h4, hi[7:5] != 3'h7, cpu_irq_n_i & !ext_pull[2],
        cpu_nmi_n_i & !ext_pull[1], cpu_rst_n_i & !ext_pull[0],
        8'h5a});
      -> look_ev;
    end
    // external master takes the bus and decodes through the port
    vid_fetch_i = 0;
    ext_pull = 0;
    ext_addr = 16'hdf33;
    want_dma = 1;
    wait_float(1);
    check({addr_oe_o, rw_oe_o, data_oe_o}, 0);
    repeat (3) @(posedge clk_i);
    #10 check(io2_sel_n_o, 0);
    want_dma = 0;
    wait_float(0);
    // processor write drives data in phi2 high
    cpu_rw_i = 0;
    cpu_wdata_i = 8'hc3;
    // let the write level reach the port registers first
    @(posedge clk_i);
    #10;
    repeat (20) if (phi2_o !== 1'b1) begin @(posedge clk_i); #10; end
    check({data_oe_o, data_o}, 16'h01c3);
    final_report;
  end
endmodule // cartridge_expansion_port_tb

// [testbench/cep_cart.sv]
module cep_cart (
  // bus view
  input  wire logic       clk_i, phi2_i, rw_i, sel_n_i, ba_i, want_dma_i,
  input  wire logic [1:0] want_cfg_i,
  // driven lines
  output logic      [7:0] d_o,
  output logic            d_oe_o,
  output logic            dma_req_n_o,
  output logic      [1:0] cfg_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_q = 8'h00;
  logic       dma_q  = 1'b1;
  assign dma_req_n_o = dma_q;
  // data only in phi2-high reads of own selects, else changing junk
  always_comb begin
    d_oe_o = phi2_i & rw_i & !sel_n_i;
    d_o = d_oe_o ? 8'h5a : ~last_q;
    cfg_n_o = ~want_cfg_i;
  end
  always @(posedge clk_i) last_q <= d_o;
  // dma request moves only in phi2 low, outside video fetch
  // looked at after the edge, so phi2 stays low across the new level
  always @(posedge clk_i) begin
    #10;
    if (!phi2_i && ba_i) dma_q <= !want_dma_i;
  end
endmodule // cep_cart

// [testbench/cep_port_sva.sv]
module cep_port_sva (
  // watched ports
  input wire logic        clk_i, nrst_i, vid_fetch_i, cpu_irq_n_i,
  input wire logic [15:0] addr_i,
  input wire logic        io1_sel_n_o, io2_sel_n_o, ba_o, cpu_float_o,
  input wire logic        low_rom_window_sel_n_o, high_rom_window_sel_n_o,
  input wire logic        addr_oe_o, rw_oe_o, phi2_o, dot_clk_o, irq_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // page of the port address
  wire [7:0] pg = addr_i[15:8];
  // ----------------------------------------------------------------
  // decode, bus hand-over, clocks and irq pull
  // ----------------------------------------------------------------
  a_io1_decode: assert property ($past(nrst_i) |->
    io1_sel_n_o == ($past(pg) != 8'hde)) else $error("io1 select wrong");
  a_io2_decode: assert property ($past(nrst_i) |->
    io2_sel_n_o == ($past(pg) != 8'hdf)) else $error("io2 select wrong");
  a_low_rom_decode: assert property ($past(nrst_i) |->
    low_rom_window_sel_n_o == ($past(pg[7:5]) != 3'h4))
    else $error("low window select wrong");
  a_high_rom_decode: assert property ($past(nrst_i) |->
    high_rom_window_sel_n_o == ($past(pg[7:5]) != 3'h7))
    else $error("high window select wrong");
  a_ba_follow: assert property ($past(nrst_i) |->
    ba_o == !$past(vid_fetch_i)) else $error("bus available wrong");
  a_float_oe: assert property (addr_oe_o == !cpu_float_o &&
    rw_oe_o == !cpu_float_o) else $error("float drivers wrong");
  a_float_phi2_low: assert property ($rose(cpu_float_o) |->
    !$past(phi2_o)) else $error("float taken in phi2 high");
  a_dot_toggle: assert property ($past(nrst_i) |->
    dot_clk_o != $past(dot_clk_o)) else $error("dot clock stuck");
  a_phi2_period: assert property ($past(nrst_i) &&
    $changed(phi2_o) |=> $stable(phi2_o) [*7]) else $error("phi2 period");
  a_irq_pull: assert property (irq_oe_o == !cpu_irq_n_i)
    else $error("irq pull wrong");
  c_io1: cover property (!io1_sel_n_o);
  c_float: cover property ($rose(cpu_float_o));
  c_ba: cover property ($fell(ba_o));
endmodule // cep_port_sva

bind cep_port cep_port_sva sva (.*);
